// file: pndp_core.sv
// serial programming, calibration gate and working dividers
//
// How it works
// - words with address 0010 go to the feedback-divider register
// - bits 5:4 pick the prescaler ratio, 01 meaning 16/17
// - bits 11:6 load the unsigned swallow count
// - bits 24:12 load the unsigned main count
// - bits 28:25 select what the test output pin shows
// - locking starts once config and divider words are written, calibration has finished, and lock-go is set or it is the first transfer after calibration
// - soft-reset bit 4 of config word clears calibration data
// - feedback counter divides VCO by swallow plus low modulus times main
// - reference divider 14 bits, swallow 6 bits, main 13 bits
// - calibration word bits 30:18 hold 13-bit target frequency
// - prescaler codes 00..11 give 8/9, 16/17, 32/33, 64/65
// - working dividers load on lock-go or on the first transfer after calibration; device clears lock-go after lock
// - each transfer is a 32-bit word, address in the low four bits
// - calibration runs 5 ms, blocks cal and divider writes, then self-clears
`timescale 1ns/1ps
module pndp_core import pndp_pkg::*; #(
	parameter int CAL_LEN = CAL_CYCLES
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic ser_clk,
	input wire logic ser_data,
	input wire logic ser_strobe,
	input wire logic lock_det,
	input wire logic vco_tick,
	output logic [PRESC_W-1:0] prescaler_ratio_sel_r,
	output logic [SWAL_W-1:0] swallow_r,
	output logic [MAIN_W-1:0] main_r,
	output logic [RDIV_W-1:0] rdiv_r,
	output logic [TGT_W-1:0] target_freq_r,
	output logic cal_busy_r,
	output logic cal_done_r,
	output logic locking_r,
	output logic lock_go_bit_r,
	output logic test_out_r,
	output logic test_out_oe_r
);
	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [SYNC_N-1:0] pin_in;
	logic [SYNC_N-1:0] sync1_r;
	logic [SYNC_N-1:0] sync2_r;
	logic [SYNC_N-1:0] sync3_r;
	assign pin_in = {vco_tick, lock_det, ser_strobe, ser_data, ser_clk};

	genvar gi;
	generate
		for (gi = 0; gi < SYNC_N; gi++) begin : g_sync
			always_ff @(posedge ref_clk) begin
				if (reset) begin
					sync1_r[gi] <= 1'b0;
					sync2_r[gi] <= 1'b0;
					sync3_r[gi] <= 1'b0;
				end else begin
					sync1_r[gi] <= pin_in[gi];
					sync2_r[gi] <= sync1_r[gi];
					sync3_r[gi] <= sync2_r[gi];
				end
			end
		end
	endgenerate

	logic sclk_rise;
	logic strobe_rise;
	logic lock_s;
	logic vco_rise;
	assign sclk_rise = sync2_r[0] & ~sync3_r[0];
	assign strobe_rise = sync2_r[2] & ~sync3_r[2];
	assign lock_s = sync2_r[3];
	assign vco_rise = sync2_r[4] & ~sync3_r[4];

	// ****************************************
	// serial shift register
	// ****************************************
	logic [WORD_W-1:0] shift_r;
	logic [ADDR_W-1:0] addr;
	logic take_cfg;
	logic take_cal;
	logic take_fb;
	assign addr = shift_r[ADDR_W-1:0];
	assign take_cfg = strobe_rise && addr == ADDR_CFG;
	assign take_cal = strobe_rise && addr == ADDR_CAL && !cal_busy_r;
	assign take_fb = strobe_rise && addr == ADDR_FB && !cal_busy_r;

	// msb first, so the address bits arrive last
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			shift_r <= '0;
		end else if (sclk_rise) begin
			shift_r <= {shift_r[WORD_W-2:0], sync2_r[1]};
		end
	end

	// ****************************************
	// configuration and calibration words
	// ****************************************
	logic soft_rst;
	logic cfg_done_r;
	logic [31:0] cal_cnt_r;
	assign soft_rst = take_cfg && shift_r[SOFT_RST_BIT];

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			cfg_done_r <= 1'b0;
			rdiv_r <= '0;
		end else if (take_cfg) begin
			cfg_done_r <= 1'b1;
			rdiv_r <= shift_r[RDIV_LSB +: RDIV_W];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			target_freq_r <= '0;
		end else if (take_cal) begin
			target_freq_r <= shift_r[TGT_LSB +: TGT_W];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			cal_busy_r <= 1'b0;
			cal_cnt_r <= '0;
		end else if (take_cal && shift_r[CAL_GO_BIT]) begin
			cal_busy_r <= 1'b1;
			cal_cnt_r <= 32'(CAL_LEN - 1);
		end else if (cal_busy_r) begin
			if (cal_cnt_r == 32'h00000000) begin
				cal_busy_r <= 1'b0;
			end else begin
				cal_cnt_r <= cal_cnt_r - 32'h00000001;
			end
		end
	end

	logic cal_end;
	assign cal_end = cal_busy_r && cal_cnt_r == 32'h00000000;

	// calibration end outranks a coincident soft reset
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			cal_done_r <= 1'b0;
		end else if (cal_end) begin
			cal_done_r <= 1'b1;
		end else if (soft_rst) begin
			cal_done_r <= 1'b0;
		end
	end

	// ****************************************
	// feedback-divider shadow and transfer
	// ****************************************
	logic [PRESC_W-1:0] sh_presc_r;
	logic [SWAL_W-1:0] sh_swal_r;
	logic [MAIN_W-1:0] sh_main_r;
	logic [TSEL_W-1:0] test_output_select_r;
	logic fb_pend_r;
	logic first_r;
	logic xfer;
	assign xfer = fb_pend_r && cfg_done_r && cal_done_r && !cal_busy_r
		&& (lock_go_bit_r || first_r);

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			sh_presc_r <= '0;
			sh_swal_r <= '0;
			sh_main_r <= '0;
			test_output_select_r <= TSEL_HIZ;
		end else if (take_fb) begin
			sh_presc_r <= shift_r[PRESC_LSB +: PRESC_W];
			sh_swal_r <= shift_r[SWAL_LSB +: SWAL_W];
			sh_main_r <= shift_r[MAIN_LSB +: MAIN_W];
			test_output_select_r <= shift_r[TSEL_LSB +: TSEL_W];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			fb_pend_r <= 1'b0;
		end else if (take_fb) begin
			fb_pend_r <= 1'b1;
		end else if (xfer || soft_rst) begin
			fb_pend_r <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			first_r <= 1'b0;
		end else if (cal_end) begin
			first_r <= 1'b1;
		end else if (xfer || soft_rst) begin
			first_r <= 1'b0;
		end
	end

	// a fresh lock-go write outranks the clear after lock
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			lock_go_bit_r <= 1'b0;
		end else if (take_fb) begin
			lock_go_bit_r <= shift_r[LOCK_GO_BIT];
		end else if (locking_r && lock_s) begin
			lock_go_bit_r <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			prescaler_ratio_sel_r <= '0;
			swallow_r <= '0;
			main_r <= '0;
		end else if (xfer) begin
			prescaler_ratio_sel_r <= sh_presc_r;
			swallow_r <= sh_swal_r;
			main_r <= sh_main_r;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			locking_r <= 1'b0;
		end else if (xfer) begin
			locking_r <= 1'b1;
		end else if (lock_s) begin
			locking_r <= 1'b0;
		end
	end

	// ****************************************
	// dividers and test output
	// ****************************************
	logic fb_pulse;
	logic [RDIV_W-1:0] rcnt_r;
	logic ref_pulse_r;

	pndp_fbdiv #(.SW_W(SWAL_W), .MN_W(MAIN_W)) u_fbdiv (
		.ref_clk(ref_clk),
		.reset(reset),
		.vco_tick(vco_rise),
		.presc(prescaler_ratio_sel_r),
		.swallow(swallow_r),
		.main_cnt(main_r),
		.fb_pulse_r(fb_pulse)
	);

	// reference divider over ref_clk, zero treated as one
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rcnt_r <= '0;
			ref_pulse_r <= 1'b0;
		end else if (rcnt_r + 14'h0001 >= rdiv_r) begin
			rcnt_r <= '0;
			ref_pulse_r <= 1'b1;
		end else begin
			rcnt_r <= rcnt_r + 14'h0001;
			ref_pulse_r <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			test_out_r <= 1'b0;
			test_out_oe_r <= 1'b0;
		end else begin
			test_out_oe_r <= 1'b1;
			case (test_output_select_r)
				TSEL_DLOCK: test_out_r <= lock_s;
				TSEL_NDIV: test_out_r <= fb_pulse;
				TSEL_HIGH: test_out_r <= 1'b1;
				TSEL_RDIV: test_out_r <= ref_pulse_r;
				TSEL_ALOCK: test_out_r <= lock_s;
				TSEL_RDBK: test_out_r <= cal_busy_r;
				TSEL_LOW: test_out_r <= 1'b0;
				default: begin
					test_out_r <= 1'b0;
					test_out_oe_r <= 1'b0;
				end
			endcase
		end
	end

	// ****************************************
	// checks
	// ****************************************
	chk_fb_route: assert property (@(posedge ref_clk) disable iff (reset)
		take_fb |=> sh_main_r == $past(shift_r[24:12]) && sh_swal_r == $past(shift_r[11:6]))
		else $error("divider word not captured");
	chk_presc_field: assert property (@(posedge ref_clk) disable iff (reset)
		take_fb |=> sh_presc_r == $past(shift_r[5:4]))
		else $error("prescaler field not captured");
	chk_cal_block: assert property (@(posedge ref_clk) disable iff (reset)
		cal_busy_r && strobe_rise |=> $stable(sh_main_r) && $stable(target_freq_r))
		else $error("write accepted during calibration");
	chk_cal_length: assert property (@(posedge ref_clk) disable iff (reset)
		$fell(cal_busy_r) |-> $past(cal_cnt_r) == 32'h00000000 && cal_done_r)
		else $error("calibration ended early");
	chk_soft_reset: assert property (@(posedge ref_clk) disable iff (reset)
		soft_rst && !cal_end |=> !cal_done_r && !first_r)
		else $error("soft reset kept calibration data");
	chk_xfer_gate: assert property (@(posedge ref_clk) disable iff (reset)
		!xfer |=> $stable(main_r) && $stable(swallow_r))
		else $error("working divider changed without transfer");
	chk_lock_clear: assert property (@(posedge ref_clk) disable iff (reset)
		locking_r && lock_s && !take_fb && !xfer |=> !lock_go_bit_r && !locking_r)
		else $error("lock-go not cleared after lock");
	chk_lock_start: assert property (@(posedge ref_clk) disable iff (reset)
		xfer |=> locking_r && main_r == $past(sh_main_r))
		else $error("locking did not start");
	chk_test_hiz: assert property (@(posedge ref_clk) disable iff (reset)
		test_output_select_r == TSEL_HIZ |=> !test_out_oe_r)
		else $error("test pin driven in high impedance mode");
	chk_test_high: assert property (@(posedge ref_clk) disable iff (reset)
		test_output_select_r == TSEL_HIGH |=> test_out_oe_r && test_out_r)
		else $error("test pin not high");

	cov_cal_run: cover property (@(posedge ref_clk) disable iff (reset) $fell(cal_busy_r));
	cov_first_xfer: cover property (@(posedge ref_clk) disable iff (reset) xfer && first_r);
	cov_lock_done: cover property (@(posedge ref_clk) disable iff (reset) locking_r && lock_s);
	cov_soft_rst: cover property (@(posedge ref_clk) disable iff (reset) soft_rst && cal_done_r);
endmodule : pndp_core

// file: pndp_pkg.sv
// constants for the feedback-divider programming block
package pndp_pkg;
	localparam int REF_CLK_HZ = 40_000_000;
	localparam int CAL_TIME_MS = 5;
	localparam int CAL_CYCLES = CAL_TIME_MS * (REF_CLK_HZ / 1000);
	localparam int WORD_W = 32;
	localparam int ADDR_W = 4;
	localparam logic [3:0] ADDR_CFG = 4'h0;
	localparam logic [3:0] ADDR_CAL = 4'h1;
	localparam logic [3:0] ADDR_FB = 4'h2;
	localparam int SOFT_RST_BIT = 4;
	localparam int RDIV_LSB = 12;
	localparam int RDIV_W = 14;
	localparam int CAL_GO_BIT = 31;
	localparam int TGT_LSB = 18;
	localparam int TGT_W = 13;
	localparam int PRESC_LSB = 4;
	localparam int PRESC_W = 2;
	localparam int SWAL_LSB = 6;
	localparam int SWAL_W = 6;
	localparam int MAIN_LSB = 12;
	localparam int MAIN_W = 13;
	localparam int TSEL_LSB = 25;
	localparam int TSEL_W = 4;
	localparam int LOCK_GO_BIT = 29;
	localparam int NDIV_W = 20;
	localparam logic [3:0] TSEL_HIZ = 4'h0;
	localparam logic [3:0] TSEL_DLOCK = 4'h1;
	localparam logic [3:0] TSEL_NDIV = 4'h2;
	localparam logic [3:0] TSEL_HIGH = 4'h3;
	localparam logic [3:0] TSEL_RDIV = 4'h4;
	localparam logic [3:0] TSEL_ALOCK = 4'h5;
	localparam logic [3:0] TSEL_RDBK = 4'h6;
	localparam logic [3:0] TSEL_LOW = 4'h7;
	localparam logic [NDIV_W-1:0] PRESC_LOW_BASE = 20'h00008;
	localparam int SYNC_N = 5;
endpackage : pndp_pkg

// file: pndp_fbdiv.sv
// feedback counter dividing synchronised vco ticks by N
`timescale 1ns/1ps
module pndp_fbdiv import pndp_pkg::*; #(
	parameter int SW_W = SWAL_W,
	parameter int MN_W = MAIN_W
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic vco_tick,
	input wire logic [PRESC_W-1:0] presc,
	input wire logic [SW_W-1:0] swallow,
	input wire logic [MN_W-1:0] main_cnt,
	output logic fb_pulse_r
);
	logic [NDIV_W-1:0] n_val;
	logic [NDIV_W-1:0] cnt_r;

	// N = A + P*B with P = 8 << code
	always_comb begin
		n_val = NDIV_W'(swallow) + ((PRESC_LOW_BASE << presc) * NDIV_W'(main_cnt));
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			cnt_r <= '0;
			fb_pulse_r <= 1'b0;
		end else begin
			fb_pulse_r <= 1'b0;
			if (vco_tick) begin
				if (cnt_r + 20'h00001 >= n_val) begin
					cnt_r <= '0;
					fb_pulse_r <= 1'b1;
				end else begin
					cnt_r <= cnt_r + 20'h00001;
				end
			end
		end
	end

	chk_ndiv_value: assert property (@(posedge ref_clk) disable iff (reset)
		presc == 2'h1 |-> n_val == NDIV_W'(swallow) + 20'h00010 * NDIV_W'(main_cnt))
		else $error("prescaler 16/17 gives wrong N");
	chk_ndiv_wrap: assert property (@(posedge ref_clk) disable iff (reset)
		fb_pulse_r |-> $past(vco_tick) && $past(cnt_r) + 20'h00001 >= $past(n_val))
		else $error("feedback pulse without full count");
endmodule : pndp_fbdiv

// file: pndp_host.sv
// partner model: host controller on the three-wire programming link
`timescale 1ns/1ps
module pndp_host (
	input wire logic ref_clk,
	output logic ser_clk,
	output logic ser_data,
	output logic ser_strobe
);
	initial begin
		ser_clk = 1'b0;
		ser_data = 1'b0;
		ser_strobe = 1'b0;
	end
	// one whole word, msb first, 200 ns link clock, clock idle low outside frames
	task automatic send(input logic [31:0] w);
		for (int i = 31; i >= 0; i--) begin
			@(negedge ref_clk);
			ser_data = w[i];
			repeat (4) @(negedge ref_clk);
			ser_clk = 1'b1;
			repeat (3) @(negedge ref_clk);
			ser_clk = 1'b0;
		end
		// released data line shows the inverse, not a held value
		ser_data = ~w[0];
		repeat (4) @(negedge ref_clk);
		ser_strobe = 1'b1;
		repeat (4) @(negedge ref_clk);
		ser_strobe = 1'b0;
	endtask : send
endmodule : pndp_host

// file: pll_n_divider_program_tb.sv
// self-checking bench for the feedback-divider programming block
`timescale 1ns/1ps
module pll_n_divider_program_tb import pndp_pkg::*;;
	localparam int CAL_T = 400;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic lock_det = 1'b0;
	logic vco_tick = 1'b0;
	logic ser_clk, ser_data, ser_strobe, cal_busy_r, cal_done_r, locking_r, lock_go_bit_r, test_out_r, test_out_oe_r;
	logic [1:0] prescaler_ratio_sel_r, m_presc;
	logic [5:0] swallow_r, m_sw;
	logic [12:0] main_r, target_freq_r, m_main, m_tgt;
	logic [13:0] rdiv_r, m_rdiv;
	logic [3:0] m_tsel;
	logic [31:0] m_q[$];
	logic [3:0] tcode[6] = '{TSEL_HIZ, TSEL_DLOCK, TSEL_HIGH, TSEL_RDBK, TSEL_LOW, TSEL_ALOCK};
	bit m_busy, m_done, m_first, m_cfg, m_lock, m_go;
	int n_mismatch = 0;
	int checks = 0;
	int cyc = 0;
	always #12.5 ref_clk = ~ref_clk;
	always begin
		repeat (3) @(negedge ref_clk);
		vco_tick = ~vco_tick;
	end
	pndp_host pndp_host_i (.ref_clk(ref_clk), .ser_clk(ser_clk), .ser_data(ser_data), .ser_strobe(ser_strobe));
	pndp_core #(.CAL_LEN(CAL_T)) pndp_core_i (
		.ref_clk(ref_clk), .reset(reset), .ser_clk(ser_clk), .ser_data(ser_data), .ser_strobe(ser_strobe),
		.lock_det(lock_det), .vco_tick(vco_tick), .prescaler_ratio_sel_r(prescaler_ratio_sel_r),
		.swallow_r(swallow_r), .main_r(main_r), .rdiv_r(rdiv_r), .target_freq_r(target_freq_r),
		.cal_busy_r(cal_busy_r), .cal_done_r(cal_done_r), .locking_r(locking_r), .lock_go_bit_r(lock_go_bit_r),
		.test_out_r(test_out_r), .test_out_oe_r(test_out_oe_r)
	);
	// ****************
	// compare and model
	// ****************
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_reg
	task automatic chk_flag(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_flag
	task automatic finish_test();
		$display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : finish_test
	task automatic try_xfer();
		if (m_q.size() > 0 && m_cfg && m_done && !m_busy && (m_q[0][LOCK_GO_BIT] || m_first)) begin
			{m_tsel, m_main, m_sw, m_presc} = m_q[0][28:4];
			m_go = m_q[0][LOCK_GO_BIT];
			m_lock = 1'b1;
			m_first = 1'b0;
			m_q = {};
		end
	endtask : try_xfer
	task automatic wr(input logic [31:0] w);
		pndp_host_i.send(w);
		repeat (8) @(negedge ref_clk);
		case (w[3:0])
			ADDR_CFG: begin
				m_cfg = 1'b1;
				m_rdiv = w[25:12];
				if (w[SOFT_RST_BIT]) begin
					m_done = 1'b0;
					m_first = 1'b0;
					m_q = {};
				end
			end
			ADDR_CAL: if (!m_busy) begin
				m_tgt = w[30:18];
				m_busy = w[CAL_GO_BIT];
			end
			ADDR_FB: if (!m_busy) begin
				m_q = {w};
				m_go = w[LOCK_GO_BIT];
			end
			default: ;
		endcase
		try_xfer();
	endtask : wr
	task automatic check_all();
		chk_reg(prescaler_ratio_sel_r, m_presc);
		chk_reg(swallow_r, m_sw);
		chk_reg(main_r, m_main);
		chk_reg(rdiv_r, m_rdiv);
		chk_reg(target_freq_r, m_tgt);
		chk_flag(cal_busy_r, m_busy);
		chk_flag(cal_done_r, m_done);
		chk_flag(locking_r, m_lock);
		chk_flag(lock_go_bit_r, m_go);
	endtask : check_all
	task automatic cal_end();
		repeat (CAL_T + 20) @(negedge ref_clk);
		m_busy = 1'b0;
		m_done = 1'b1;
		m_first = 1'b1;
		try_xfer();
		check_all();
	endtask : cal_end
	task automatic lock_done();
		lock_det = 1'b1;
		repeat (6) @(negedge ref_clk);
		m_lock = 1'b0;
		m_go = 1'b0;
		check_all();
		lock_det = 1'b0;
		repeat (6) @(negedge ref_clk);
	endtask : lock_done
	// host keeps main count 64..8191 and not below swallow
	function automatic logic [31:0] fbw(input logic [1:0] p, input logic [3:0] ts, input logic go);
		logic [12:0] mn;
		logic [5:0] sw;
		mn = 13'(64 + $urandom % 8128);
		sw = 6'($urandom);
		return {2'h0, go, ts, mn, sw, p, ADDR_FB};
	endfunction : fbw
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			finish_test();
		end
	end
	// ****************
	// main sequence
	// ****************
	initial begin
		void'($urandom(9213));
		m_presc = '0;
		m_sw = '0;
		m_main = '0;
		m_rdiv = '0;
		m_tgt = '0;
		m_tsel = '0;
		repeat (20) @(negedge ref_clk);
		reset = 1'b0;
		check_all();
		chk_flag(test_out_oe_r, 1'b0);
		wr({6'h00, 14'($urandom), 7'h00, 1'b0, ADDR_CFG});
		wr({1'b1, 13'($urandom), 14'h0000, ADDR_CAL});
		wr(fbw(2'h1, 4'h0, 1'b1));
		check_all();
		cal_end();
		wr(fbw(2'h1, 4'h0, 1'b0));
		check_all();
		lock_done();
		wr(fbw(2'h2, 4'h0, 1'b0));
		check_all();
		for (int p = 0; p < 4; p++) begin
			wr(fbw(2'(p), 4'h0, 1'b1));
			check_all();
			lock_done();
		end
		foreach (tcode[i]) begin
			wr(fbw(2'h0, tcode[i], 1'b1));
			chk_flag(test_out_oe_r, tcode[i] != TSEL_HIZ);
			if (tcode[i] != TSEL_HIZ) chk_flag(test_out_r, tcode[i] == TSEL_HIGH);
			lock_done();
		end
		wr(fbw(2'h3, 4'h0, 1'b1) | 32'hC0000000);
		check_all();
		lock_done();
		wr(32'h5A5A5A5F);
		check_all();
		wr({6'h00, 14'($urandom), 7'h00, 1'b1, ADDR_CFG});
		wr({6'h00, 14'($urandom), 7'h00, 1'b0, ADDR_CFG});
		wr(fbw(2'h0, 4'h0, 1'b1));
		check_all();
		wr({1'b1, 13'($urandom), 14'h0000, ADDR_CAL});
		cal_end();
		lock_done();
		finish_test();
	end
endmodule : pll_n_divider_program_tb
